/* hw/setups_pkg.sv */
package setups_pkg;

	localparam int unsigned NUM_KEYS = 48;
	localparam int unsigned BLOCK_BYTES = 350;

	localparam logic [8:0] ADDR_THRESHOLD = 9'h000;
	localparam logic [8:0] ADDR_DRIFT = 9'h030;
	localparam logic [8:0] ADDR_INTEGRATOR = 9'h060;
	localparam logic [8:0] ADDR_NEG_RECAL = 9'h090;
	localparam logic [8:0] ADDR_POS_RECAL_BURST = 9'h0C0;
	localparam logic [8:0] ADDR_FREQ_OFFSET_ONE = 9'h0F0;
	localparam logic [8:0] ADDR_FREQ_OFFSET_TWO = 9'h120;
	localparam logic [8:0] ADDR_GLOBAL_FIRST = 9'h150;
	localparam logic [8:0] ADDR_DWELL_BAUD = 9'h151;
	localparam logic [8:0] ADDR_SIGNAL_LIMIT = 9'h152;
	localparam logic [8:0] ADDR_STATUS_SELECT = 9'h154;
	localparam logic [8:0] ADDR_FREQ_ZERO_HOP = 9'h157;
	localparam logic [8:0] ADDR_FREQ_ONE = 9'h158;
	localparam logic [8:0] ADDR_FREQ_TWO = 9'h159;
	localparam logic [8:0] ADDR_GLOBAL_LAST = 9'h15A;
	localparam logic [8:0] ADDR_CRC_LO = 9'h15C;
	localparam logic [8:0] ADDR_CRC_HI = 9'h15D;
	localparam int unsigned NUM_GLOBALS = 11;

	localparam int unsigned G_HYST = 0;
	localparam int unsigned G_DWELL = 1;
	localparam int unsigned G_LIMIT_LO = 2;
	localparam int unsigned G_LIMIT_HI = 3;
	localparam int unsigned G_STATUS = 4;
	localparam int unsigned G_PRIMARY_FREQUENCY = 7;
	localparam int unsigned G_SECOND_FREQUENCY = 8;
	localparam int unsigned G_THIRD_FREQUENCY = 9;

	localparam logic [7:0] RST_THRESHOLD = 8'h26;
	localparam logic [7:0] RST_DRIFT = 8'hAA;
	localparam logic [7:0] RST_INTEGRATOR = 8'h52;
	localparam logic [7:0] RST_NEG_RECAL = 8'h14;
	localparam logic [7:0] RST_POS_RECAL_BURST = 8'h26;
	localparam logic [7:0] RST_FREQ_OFFSET = 8'h00;
	localparam logic [7:0] RST_HYST = 8'h01;
	localparam logic [7:0] RST_DWELL_BAUD = 8'h01;
	localparam logic [7:0] RST_LIMIT_LO = 8'h64;
	localparam logic [7:0] RST_LIMIT_HI = 8'h70;
	localparam logic [7:0] RST_STATUS_SELECT = 8'h20;
	localparam logic [7:0] RST_AWAKE_HOLD = 8'hBF;
	localparam logic [7:0] RST_FREQ_ZERO_HOP = 8'h58;
	localparam logic [7:0] RST_FREQ_ONE = 8'h1E;
	localparam logic [7:0] RST_FREQ_TWO = 8'h24;
	localparam logic [7:0] RST_NOISE = 8'h30;
	localparam logic [7:0] RST_ZERO = 8'h00;

	localparam logic [7:0] CMD_SETUP_ENTRY = 8'h01;
	localparam logic [7:0] CMD_AUTO_OFFSET = 8'h02;
	localparam logic [1:0] HOP_ADJUST = 2'h2;
	localparam logic [3:0] BAUD_CODE_MAX = 4'h4;
	localparam logic [4:0] THRESHOLD_BIAS = 5'h04;
	localparam logic [7:0] RECAL_ILLEGAL = 8'hFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;

	localparam int unsigned STS_BIT_DEBUG = 7;
	localparam int unsigned STS_BIT_KEY_ERROR = 6;
	localparam int unsigned STS_BIT_TOUCH = 5;
	localparam int unsigned STS_BIT_CRC = 3;
	localparam int unsigned STS_BIT_MAINS = 2;

	typedef enum logic [3:0] {
		ST_INIT = 4'b0000,
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_LOAD = 4'b0011,
		ST_CAL = 4'b0100,
		ST_SCAN = 4'b0101,
		ST_CRC_LO = 4'b0110,
		ST_CRC_HI = 4'b0111,
		ST_HOP = 4'b1000
	} loader_state_t;

	function automatic logic [15:0] crc16_step(input logic [15:0] crc,
		input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {data, 8'h00};
		for (int i = 0; i < 8; i++)
		begin
			c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc16_step

	function automatic logic [7:0] default_byte(input logic [8:0] a);
		logic [7:0] v;
		v = RST_ZERO;
		if (a < ADDR_DRIFT) v = RST_THRESHOLD;
		else if (a < ADDR_INTEGRATOR) v = RST_DRIFT;
		else if (a < ADDR_NEG_RECAL) v = RST_INTEGRATOR;
		else if (a < ADDR_POS_RECAL_BURST) v = RST_NEG_RECAL;
		else if (a < ADDR_FREQ_OFFSET_ONE) v = RST_POS_RECAL_BURST;
		else if (a < ADDR_GLOBAL_FIRST) v = RST_FREQ_OFFSET;
		else if (a == ADDR_GLOBAL_FIRST) v = RST_HYST;
		else if (a == ADDR_DWELL_BAUD) v = RST_DWELL_BAUD;
		else if (a == ADDR_SIGNAL_LIMIT) v = RST_LIMIT_LO;
		else if (a == ADDR_SIGNAL_LIMIT + 9'h001) v = RST_LIMIT_HI;
		else if (a == ADDR_STATUS_SELECT) v = RST_STATUS_SELECT;
		else if (a == ADDR_STATUS_SELECT + 9'h001) v = RST_AWAKE_HOLD;
		else if (a == ADDR_FREQ_ZERO_HOP) v = RST_FREQ_ZERO_HOP;
		else if (a == ADDR_FREQ_ONE) v = RST_FREQ_ONE;
		else if (a == ADDR_FREQ_TWO) v = RST_FREQ_TWO;
		else if (a == ADDR_GLOBAL_LAST) v = RST_NOISE;
		return v;
	endfunction : default_byte

endpackage : setups_pkg

/* hw/setup_store.sv */
`timescale 1ns/1ps
`default_nettype none

module setup_store (
	// Clock
	input wire logic clock_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [8:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	// Read port, registered data
	input wire logic rd_en_i,
	input wire logic [8:0] rd_addr_i,
	output logic [7:0] rd_data_o
);

	logic [7:0] mem_q [0:setups_pkg::BLOCK_BYTES-1];

	always_ff @(posedge clock_i)
	begin
		if (wr_en_i && (wr_addr_i < 9'(setups_pkg::BLOCK_BYTES)))
		begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i)
		begin
			rd_data_o <= (rd_addr_i < 9'(setups_pkg::BLOCK_BYTES)) ?
				mem_q[rd_addr_i] : 8'h00;
		end
	end

endmodule : setup_store

`default_nettype wire

/* hw/setups_loader.sv */
// Notes on behaviour
// - Hop mode 2: each hop adjusts key references by offsets.
// - Offsets relative to highest frequency; one table per lower one.
// - A command fills both offset tables; host may write them too.
// - 48-byte offset tables at 240 and 288, default zero.
// - Block ends with 16-bit CRC, low byte first.
// - Block taken only in setup mode: entry command twice.
// - Bytes 0-47: thresholds, negative low nibble, operand plus 4.
// - Bytes 48-95: drift compensation nibbles, default 10.
// - Bytes 96-143: integrator limits; 0 no burst, fast 0 invalid.
// - Bytes 144-191: negative recal delay; 0 infinite, 255 illegal.
// - Bytes 192-239: positive recal delay, burst length, suppression.
// - Byte 336: hysteresis, sleep drift, mains sync, multiplier.
// - Byte 337: dwell code, baud codes 0-4.
// - Bytes 338-339: signal limit, restart burst, gain test.
// - Byte 340 selects status pin conditions, default 0x20.
// - CRC at 348-349 covers the setup bytes before it.
// - Status pin low on CRC mismatch when selected and debug bit 7 clear.
`timescale 1ns/1ps
`default_nettype none

module setups_loader (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Serial byte stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	output logic rx_ready_o,
	output logic setup_mode_o,
	output logic load_done_o,
	// Automatic offset fill
	output logic [5:0] cal_key_o,
	input wire logic [15:0] cal_ref_high_i,
	input wire logic [15:0] cal_ref_one_i,
	input wire logic [15:0] cal_ref_two_i,
	output logic cal_busy_o,
	// Frequency hops
	input wire logic hop_event_i,
	input wire logic [1:0] hop_freq_i,
	output logic hop_ready_o,
	output logic adj_valid_o,
	output logic [5:0] adj_key_o,
	output logic [8:0] adj_delta_o,
	// Per-key setting query
	input wire logic query_valid_i,
	input wire logic [2:0] query_table_i,
	input wire logic [5:0] query_key_i,
	output logic query_ready_o,
	output logic query_ans_o,
	output logic [7:0] query_data_o,
	output logic [4:0] negative_threshold_o,
	output logic [4:0] positive_threshold_o,
	output logic burst_disabled_o,
	output logic fast_limit_invalid_o,
	output logic recal_infinite_o,
	output logic recal_illegal_o,
	// Global settings
	output logic [1:0] hop_mode_o,
	output logic [5:0] primary_frequency_o,
	output logic [5:0] second_frequency_o,
	output logic [5:0] third_frequency_o,
	output logic [1:0] negative_hysteresis_o,
	output logic [2:0] sleep_drift_comp_o,
	output logic sleep_enable_o,
	output logic mains_sync_enable_o,
	output logic [1:0] threshold_multiplier_o,
	output logic [3:0] dwell_code_o,
	output logic [3:0] baud_select_o,
	output logic baud_valid_o,
	output logic [10:0] lower_signal_limit_o,
	output logic restart_interrupted_burst_o,
	output logic [3:0] key_gain_test_threshold_o,
	output logic [7:0] status_select_o,
	// Signal check and status pin
	input wire logic [15:0] key_signal_i,
	output logic signal_low_o,
	input wire logic key_error_i,
	input wire logic touch_change_i,
	input wire logic mains_sync_error_i,
	input wire logic debug_i,
	output logic crc_mismatch_o,
	output logic status_n_o
);

	////////////////////////////////////////////////////////////////////////
	setups_pkg::loader_state_t state_q, state_d;
	logic [8:0] addr_q, addr_d;
	logic [5:0] key_q, key_d;
	logic [1:0] phase_q, phase_d;
	logic [15:0] crc_q, crc_d;
	logic [7:0] crc_lo_q, crc_lo_d;
	logic [7:0] off1_q, off1_d;
	logic [1:0] freq_idx_q, freq_idx_d;
	logic [1:0] old_idx_q, old_idx_d;
	logic fix_q, fix_d;
	logic scan_vld_q, scan_vld_d;
	logic [8:0] scan_at_q, scan_at_d;
	logic mismatch_q, mismatch_d;
	logic query_pend_q, query_pend_d;
	logic load_done_q, load_done_d;
	logic adj_valid_q, adj_valid_d;
	logic [5:0] adj_key_q, adj_key_d;
	logic [8:0] adj_delta_q, adj_delta_d;
	logic status_n_q, status_n_d;
	logic signal_low_q, signal_low_d;
	logic [7:0] glob_q [0:setups_pkg::NUM_GLOBALS-1];

	logic wr_en;
	logic [8:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_en;
	logic [8:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] cfo_new;
	logic [7:0] cfo_old;

	setup_store u_store (
		.clock_i(clock_i),
		.wr_en_i(wr_en),
		.wr_addr_i(wr_addr),
		.wr_data_i(wr_data),
		.rd_en_i(rd_en),
		.rd_addr_i(rd_addr),
		.rd_data_o(rd_data)
	);

	function automatic logic [7:0] clamp_diff(input logic [15:0] hi,
		input logic [15:0] lo);
		logic [16:0] d;
		d = {1'b0, hi} - {1'b0, lo};
		if (d[16]) return 8'h00;
		if (d[15:8] != 8'h00) return 8'hFF;
		return d[7:0];
	endfunction : clamp_diff

	function automatic logic [7:0] offset_of(input logic [1:0] idx,
		input logic [7:0] one, input logic [7:0] two);
		if (idx == 2'h1) return one;
		if (idx == 2'h2) return two;
		return 8'h00;
	endfunction : offset_of

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_d = state_q;
		addr_d = addr_q;
		key_d = key_q;
		phase_d = phase_q;
		crc_d = crc_q;
		crc_lo_d = crc_lo_q;
		off1_d = off1_q;
		freq_idx_d = freq_idx_q;
		old_idx_d = old_idx_q;
		fix_d = fix_q;
		scan_vld_d = 1'b0;
		scan_at_d = scan_at_q;
		mismatch_d = mismatch_q;
		query_pend_d = 1'b0;
		load_done_d = 1'b0;
		adj_valid_d = 1'b0;
		adj_key_d = adj_key_q;
		adj_delta_d = adj_delta_q;
		wr_en = 1'b0;
		wr_addr = addr_q;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_addr = addr_q;
		cfo_old = 8'h00;
		cfo_new = 8'h00;
		case (state_q)
			setups_pkg::ST_INIT:
			begin
				wr_en = 1'b1;
				wr_data = setups_pkg::default_byte(addr_q);
				if (addr_q == setups_pkg::ADDR_CRC_LO) wr_data = crc_q[7:0];
				else if (addr_q == setups_pkg::ADDR_CRC_HI) wr_data = crc_q[15:8];
				else crc_d = setups_pkg::crc16_step(crc_q, wr_data);
				addr_d = addr_q + 9'h001;
				if (addr_q == setups_pkg::ADDR_CRC_HI) state_d = setups_pkg::ST_IDLE;
			end
			setups_pkg::ST_IDLE:
			begin
				if (hop_event_i && (hop_freq_i != 2'h3))
				begin
					freq_idx_d = hop_freq_i;
					old_idx_d = freq_idx_q;
					key_d = 6'h00;
					phase_d = 2'h0;
					if (hop_mode_o == setups_pkg::HOP_ADJUST)
						state_d = setups_pkg::ST_HOP;
				end
				else if (rx_valid_i && (rx_byte_i == setups_pkg::CMD_SETUP_ENTRY))
					state_d = setups_pkg::ST_ARMED;
				else if (rx_valid_i && (rx_byte_i == setups_pkg::CMD_AUTO_OFFSET))
				begin
					key_d = 6'h00;
					phase_d = 2'h0;
					state_d = setups_pkg::ST_CAL;
				end
				else if (query_valid_i)
				begin
					rd_en = 1'b1;
					rd_addr = ({6'h00, query_table_i} * 9'd48) +
						{3'b000, query_key_i};
					query_pend_d = 1'b1;
				end
			end
			setups_pkg::ST_ARMED:
			begin
				if (rx_valid_i)
				begin
					addr_d = 9'h000;
					// Entry must come twice in a row; anything else drops it
					state_d = (rx_byte_i == setups_pkg::CMD_SETUP_ENTRY) ?
						setups_pkg::ST_LOAD : setups_pkg::ST_IDLE;
				end
			end
			setups_pkg::ST_LOAD:
			begin
				if (rx_valid_i)
				begin
					wr_en = 1'b1;
					wr_data = rx_byte_i;
					addr_d = addr_q + 9'h001;
					if (addr_q == setups_pkg::ADDR_CRC_HI)
					begin
						addr_d = 9'h000;
						crc_d = setups_pkg::CRC_INIT;
						fix_d = 1'b0;
						state_d = setups_pkg::ST_SCAN;
					end
				end
			end
			setups_pkg::ST_CAL:
			begin
				wr_en = 1'b1;
				phase_d = phase_q ^ 2'h1;
				if (phase_q == 2'h0)
				begin
					wr_addr = setups_pkg::ADDR_FREQ_OFFSET_ONE + {3'b000, key_q};
					wr_data = clamp_diff(cal_ref_high_i, cal_ref_one_i);
				end
				else
				begin
					wr_addr = setups_pkg::ADDR_FREQ_OFFSET_TWO + {3'b000, key_q};
					wr_data = clamp_diff(cal_ref_high_i, cal_ref_two_i);
					key_d = key_q + 6'h01;
					if (key_q == 6'(setups_pkg::NUM_KEYS - 1))
					begin
						addr_d = 9'h000;
						crc_d = setups_pkg::CRC_INIT;
						fix_d = 1'b1;
						state_d = setups_pkg::ST_SCAN;
					end
				end
			end
			setups_pkg::ST_SCAN:
			begin
				if (addr_q <= setups_pkg::ADDR_CRC_HI)
				begin
					rd_en = 1'b1;
					scan_vld_d = 1'b1;
					scan_at_d = addr_q;
					addr_d = addr_q + 9'h001;
				end
				if (scan_vld_q)
				begin
					if (scan_at_q < setups_pkg::ADDR_CRC_LO)
						crc_d = setups_pkg::crc16_step(crc_q, rd_data);
					else if (scan_at_q == setups_pkg::ADDR_CRC_LO)
						crc_lo_d = rd_data;
					else
					begin
						mismatch_d = ({rd_data, crc_lo_q} != crc_q);
						if (fix_q) state_d = setups_pkg::ST_CRC_LO;
						else
						begin
							load_done_d = 1'b1;
							state_d = setups_pkg::ST_IDLE;
						end
					end
				end
			end
			setups_pkg::ST_CRC_LO:
			begin
				wr_en = 1'b1;
				wr_addr = setups_pkg::ADDR_CRC_LO;
				wr_data = crc_q[7:0];
				state_d = setups_pkg::ST_CRC_HI;
			end
			setups_pkg::ST_CRC_HI:
			begin
				wr_en = 1'b1;
				wr_addr = setups_pkg::ADDR_CRC_HI;
				wr_data = crc_q[15:8];
				mismatch_d = 1'b0;
				state_d = setups_pkg::ST_IDLE;
			end
			setups_pkg::ST_HOP:
			begin
				phase_d = phase_q + 2'h1;
				if (phase_q == 2'h0)
				begin
					rd_en = 1'b1;
					rd_addr = setups_pkg::ADDR_FREQ_OFFSET_ONE + {3'b000, key_q};
				end
				else if (phase_q == 2'h1)
				begin
					rd_en = 1'b1;
					rd_addr = setups_pkg::ADDR_FREQ_OFFSET_TWO + {3'b000, key_q};
					off1_d = rd_data;
				end
				else
				begin
					cfo_old = offset_of(old_idx_q, off1_q, rd_data);
					cfo_new = offset_of(freq_idx_q, off1_q, rd_data);
					adj_valid_d = 1'b1;
					adj_key_d = key_q;
					adj_delta_d = {1'b0, cfo_old} - {1'b0, cfo_new};
					phase_d = 2'h0;
					key_d = key_q + 6'h01;
					if (key_q == 6'(setups_pkg::NUM_KEYS - 1))
						state_d = setups_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_d = setups_pkg::ST_IDLE;
			end
		endcase
	end

	always_comb
	begin
		signal_low_d = (key_signal_i < {5'h00, lower_signal_limit_o});
		if (status_select_o[setups_pkg::STS_BIT_DEBUG])
			status_n_d = ~debug_i;
		else
			status_n_d = ~((status_select_o[setups_pkg::STS_BIT_KEY_ERROR] &&
				key_error_i) ||
				(status_select_o[setups_pkg::STS_BIT_TOUCH] && touch_change_i) ||
				(status_select_o[setups_pkg::STS_BIT_CRC] && mismatch_q) ||
				(status_select_o[setups_pkg::STS_BIT_MAINS] &&
				mains_sync_error_i));
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= setups_pkg::ST_INIT;
			addr_q <= 9'h000;
			key_q <= 6'h00;
			phase_q <= 2'h0;
			crc_q <= setups_pkg::CRC_INIT;
			crc_lo_q <= 8'h00;
			off1_q <= 8'h00;
			freq_idx_q <= 2'h0;
			old_idx_q <= 2'h0;
			fix_q <= 1'b0;
			scan_vld_q <= 1'b0;
			scan_at_q <= 9'h000;
			mismatch_q <= 1'b0;
			query_pend_q <= 1'b0;
			load_done_q <= 1'b0;
			adj_valid_q <= 1'b0;
			adj_key_q <= 6'h00;
			adj_delta_q <= 9'h000;
			status_n_q <= 1'b1;
			signal_low_q <= 1'b0;
			for (int g = 0; g < setups_pkg::NUM_GLOBALS; g++)
				glob_q[g] <= setups_pkg::default_byte(
					setups_pkg::ADDR_GLOBAL_FIRST + 9'(g));
		end
		else
		begin
			state_q <= state_d;
			addr_q <= addr_d;
			key_q <= key_d;
			phase_q <= phase_d;
			crc_q <= crc_d;
			crc_lo_q <= crc_lo_d;
			off1_q <= off1_d;
			freq_idx_q <= freq_idx_d;
			old_idx_q <= old_idx_d;
			fix_q <= fix_d;
			scan_vld_q <= scan_vld_d;
			scan_at_q <= scan_at_d;
			mismatch_q <= mismatch_d;
			query_pend_q <= query_pend_d;
			load_done_q <= load_done_d;
			adj_valid_q <= adj_valid_d;
			adj_key_q <= adj_key_d;
			adj_delta_q <= adj_delta_d;
			status_n_q <= status_n_d;
			signal_low_q <= signal_low_d;
			// Global bytes are mirrored in flops: they steer logic every cycle
			if (wr_en && (wr_addr >= setups_pkg::ADDR_GLOBAL_FIRST) &&
				(wr_addr <= setups_pkg::ADDR_GLOBAL_LAST))
				glob_q[4'(wr_addr - setups_pkg::ADDR_GLOBAL_FIRST)] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign rx_ready_o = (state_q == setups_pkg::ST_IDLE) ||
		(state_q == setups_pkg::ST_ARMED) || (state_q == setups_pkg::ST_LOAD);
	assign setup_mode_o = (state_q == setups_pkg::ST_LOAD);
	assign load_done_o = load_done_q;
	assign cal_key_o = key_q;
	assign cal_busy_o = (state_q == setups_pkg::ST_CAL);
	assign hop_ready_o = (state_q == setups_pkg::ST_IDLE);
	assign adj_valid_o = adj_valid_q;
	assign adj_key_o = adj_key_q;
	assign adj_delta_o = adj_delta_q;
	assign query_ready_o = (state_q == setups_pkg::ST_IDLE) && !hop_event_i &&
		!rx_valid_i;
	assign query_ans_o = query_pend_q;
	assign query_data_o = rd_data;
	assign negative_threshold_o = {1'b0, rd_data[3:0]} +
		setups_pkg::THRESHOLD_BIAS;
	assign positive_threshold_o = {1'b0, rd_data[7:4]} +
		setups_pkg::THRESHOLD_BIAS;
	assign burst_disabled_o = (rd_data[3:0] == 4'h0);
	assign fast_limit_invalid_o = (rd_data[7:4] == 4'h0);
	assign recal_infinite_o = (rd_data == 8'h00);
	assign recal_illegal_o = (rd_data == setups_pkg::RECAL_ILLEGAL);
	assign hop_mode_o = glob_q[setups_pkg::G_PRIMARY_FREQUENCY][7:6];
	assign primary_frequency_o = glob_q[setups_pkg::G_PRIMARY_FREQUENCY][5:0];
	assign second_frequency_o = glob_q[setups_pkg::G_SECOND_FREQUENCY][5:0];
	assign third_frequency_o = glob_q[setups_pkg::G_THIRD_FREQUENCY][5:0];
	assign negative_hysteresis_o = glob_q[setups_pkg::G_HYST][1:0];
	assign sleep_drift_comp_o = glob_q[setups_pkg::G_HYST][4:2];
	assign sleep_enable_o = (glob_q[setups_pkg::G_HYST][4:2] != 3'h0);
	assign mains_sync_enable_o = glob_q[setups_pkg::G_HYST][5];
	assign threshold_multiplier_o = glob_q[setups_pkg::G_HYST][7:6];
	assign dwell_code_o = glob_q[setups_pkg::G_DWELL][3:0];
	assign baud_select_o = glob_q[setups_pkg::G_DWELL][7:4];
	assign baud_valid_o = (glob_q[setups_pkg::G_DWELL][7:4] <=
		setups_pkg::BAUD_CODE_MAX);
	assign lower_signal_limit_o = {glob_q[setups_pkg::G_LIMIT_HI][2:0],
		glob_q[setups_pkg::G_LIMIT_LO]};
	assign restart_interrupted_burst_o = glob_q[setups_pkg::G_LIMIT_HI][3];
	assign key_gain_test_threshold_o = glob_q[setups_pkg::G_LIMIT_HI][7:4];
	assign status_select_o = glob_q[setups_pkg::G_STATUS];
	assign signal_low_o = signal_low_q;
	assign crc_mismatch_o = mismatch_q;
	assign status_n_o = status_n_q;

endmodule : setups_loader

`default_nettype wire

/* sim/setups_loader_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module setups_loader_properties (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Query
	input wire logic query_valid_i,
	input wire logic query_ready_o,
	input wire logic query_ans_o,
	input wire logic [7:0] query_data_o,
	input wire logic [4:0] negative_threshold_o,
	input wire logic [4:0] positive_threshold_o,
	input wire logic burst_disabled_o,
	input wire logic fast_limit_invalid_o,
	input wire logic recal_infinite_o,
	input wire logic recal_illegal_o,
	// Hop walk
	input wire logic adj_valid_o,
	input wire logic [5:0] adj_key_o,
	input wire logic [1:0] hop_mode_o,
	// Load and status
	input wire logic setup_mode_o,
	input wire logic load_done_o,
	input wire logic crc_mismatch_o,
	input wire logic [7:0] status_select_o,
	input wire logic status_n_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_query_taken: assert property (
		query_valid_i && query_ready_o |=> query_ans_o)
		else $error("query not answered");
	chk_thresh_bias: assert property (query_ans_o |->
		negative_threshold_o == {1'h0, query_data_o[3:0]} + 5'h04 &&
		positive_threshold_o == {1'h0, query_data_o[7:4]} + 5'h04)
		else $error("threshold decode wrong");
	chk_limit_flags: assert property (query_ans_o |->
		burst_disabled_o == (query_data_o[3:0] == 4'h0) &&
		fast_limit_invalid_o == (query_data_o[7:4] == 4'h0))
		else $error("limit flags wrong");
	chk_recal_codes: assert property (query_ans_o |->
		recal_infinite_o == (query_data_o == 8'h00) &&
		recal_illegal_o == (query_data_o == 8'hFF))
		else $error("recal flags wrong");
	chk_adj_walk: assert property (
		adj_valid_o && adj_key_o != 6'h2F |=> !adj_valid_o [*2] ##1
		(adj_valid_o && adj_key_o == $past(adj_key_o, 3) + 6'h01))
		else $error("adjust walk out of step");
	chk_adj_mode: assert property (adj_valid_o |-> hop_mode_o == 2'h2)
		else $error("adjust outside hop mode 2");
	chk_load_done: assert property (
		$fell(setup_mode_o) |-> ##[340:360] load_done_o)
		else $error("no check after block");
	chk_crc_status: assert property (
		status_select_o == 8'h08 && crc_mismatch_o |=> !status_n_o)
		else $error("status pin missed mismatch");

	cover property (load_done_o && crc_mismatch_o);
	cover property (adj_valid_o && adj_key_o == 6'h2F);
	cover property (query_ans_o && recal_infinite_o);
endmodule : setups_loader_properties

bind setups_loader setups_loader_properties props (.*);

`default_nettype wire

/* sim/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model (
	// Clock
	input wire logic clock_i,
	// Byte stream into the loader
	input wire logic rx_ready_i,
	output var logic rx_valid_o,
	output var logic [7:0] rx_byte_o
);
	localparam logic [7:0] GLOB [12] = '{8'hE5, 8'h43, 8'h34, 8'hA9, 8'h08,
		8'hFF, 8'h00, 8'h90, 8'h14, 8'h18, 8'h30, 8'h00};
	logic [7:0] blk [350];

	initial
	begin
		rx_valid_o = 1'h0;
		rx_byte_o = 8'h00;
		for (int i = 0; i < 240; i++)
			blk[i] = i[7:0] ^ 8'h5A;
		for (int k = 0; k < 48; k++)
		begin
			blk[240 + k] = k[7:0];
			blk[288 + k] = 8'(2 * k);
		end
		for (int g = 0; g < 12; g++)
			blk[336 + g] = GLOB[g];
	end

	////////////////////////////////////////
	task automatic send(input logic [7:0] b);
		rx_valid_o <= 1'h1;
		rx_byte_o <= b;
		do @(posedge clock_i); while (rx_ready_i !== 1'h1);
		rx_valid_o <= 1'h0;
		@(posedge clock_i);
	endtask : send

	task automatic block(input logic bad);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < 348; i++)
		begin
			send(blk[i]);
			c = c ^ {blk[i], 8'h00};
			for (int j = 0; j < 8; j++)
				c = c[15] ? ((c << 1) ^ 16'h8005) : (c << 1);
		end
		c[0] = c[0] ^ bad;
		send(c[7:0]);
		send(c[15:8]);
	endtask : block
endmodule : host_model

`default_nettype wire

/* sim/touch_setups_block_loader_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module touch_setups_block_loader_tb_top;
	logic clock_i, rst_b_i, rx_valid_i, rx_ready_o, setup_mode_o;
	logic load_done_o, cal_busy_o, hop_event_i, hop_ready_o, adj_valid_o;
	logic query_valid_i, query_ready_o, query_ans_o, burst_disabled_o;
	logic fast_limit_invalid_o, recal_infinite_o, recal_illegal_o;
	logic sleep_enable_o, mains_sync_enable_o, baud_valid_o, signal_low_o;
	logic restart_interrupted_burst_o, key_error_i, touch_change_i, debug_i;
	logic mains_sync_error_i, crc_mismatch_o, status_n_o;
	logic [1:0] hop_freq_i, hop_mode_o, negative_hysteresis_o;
	logic [1:0] threshold_multiplier_o;
	logic [2:0] query_table_i, sleep_drift_comp_o;
	logic [3:0] dwell_code_o, baud_select_o, key_gain_test_threshold_o;
	logic [4:0] negative_threshold_o, positive_threshold_o;
	logic [5:0] cal_key_o, adj_key_o, query_key_i, primary_frequency_o;
	logic [5:0] second_frequency_o, third_frequency_o;
	logic [7:0] rx_byte_i, query_data_o, status_select_o, qd;
	logic [8:0] adj_delta_o;
	logic [9:0] qth;
	logic [10:0] lower_signal_limit_o;
	logic [15:0] cal_ref_high_i, cal_ref_one_i, cal_ref_two_i, key_signal_i;
	int mismatches = 0;
	int checks_done = 0;

	assign cal_ref_high_i = 16'h0200 + {10'h000, cal_key_o};
	assign cal_ref_one_i = cal_ref_high_i - {7'h00, cal_key_o, 3'h0};
	assign cal_ref_two_i = cal_ref_high_i + 16'h0005;

	setups_loader dut (.*);
	host_model host (
		.clock_i(clock_i),
		.rx_ready_i(rx_ready_o),
		.rx_valid_o(rx_valid_i),
		.rx_byte_o(rx_byte_i)
	);

	initial
	begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end

	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic query(input logic [2:0] t, input logic [5:0] k);
		query_valid_i <= 1'h1;
		query_table_i <= t;
		query_key_i <= k;
		do @(posedge clock_i); while (query_ready_o !== 1'h1);
		query_valid_i <= 1'h0;
		@(posedge clock_i);
		qd = query_data_o;
		qth = {negative_threshold_o, positive_threshold_o};
	endtask : query

	task automatic idle_wait;
		int n;
		n = 0;
		while (query_ready_o !== 1'h1 && n < 2000)
		begin
			@(posedge clock_i);
			n++;
		end
		check(n < 2000, 1'h1);
	endtask : idle_wait

	task automatic globals(input logic [7:0] g0, g1, input logic [15:0] g2,
		input logic [7:0] g4, f0, f1, f2);
		check({threshold_multiplier_o, mains_sync_enable_o,
			sleep_drift_comp_o, negative_hysteresis_o}, g0);
		check(sleep_enable_o, g0[4:2] != 3'h0);
		check({baud_select_o, dwell_code_o}, g1);
		check(baud_valid_o, g1[7:4] <= 4'h4);
		check({key_gain_test_threshold_o, restart_interrupted_burst_o,
			lower_signal_limit_o}, g2);
		check(status_select_o, g4);
		check({hop_mode_o, primary_frequency_o, second_frequency_o,
			third_frequency_o}, {f0, f1[5:0], f2[5:0]});
	endtask : globals

	task automatic t_defaults;
		logic [7:0] e [7];
		e = '{8'h26, 8'hAA, 8'h52, 8'h14, 8'h26, 8'h00, 8'h00};
		globals(8'h01, 8'h01, 16'h7064, 8'h20, 8'h58, 8'h1E, 8'h24);
		check({crc_mismatch_o, status_n_o}, 2'h1);
		for (int t = 6; t >= 0; t--)
		begin
			query(t[2:0], 6'h2F);
			check(qd, e[t]);
		end
		check(qth, {5'h0A, 5'h06});
		key_signal_i <= 16'h0063;
		touch_change_i <= 1'h1;
		repeat (3) @(posedge clock_i);
		check(signal_low_o, 1'h1);
		check(status_n_o, 1'h0);
		key_signal_i <= 16'h0064;
		touch_change_i <= 1'h0;
		repeat (3) @(posedge clock_i);
		check(signal_low_o, 1'h0);
		check(status_n_o, 1'h1);
		$display("defaults done");
	endtask : t_defaults

	task automatic t_hop(input logic [1:0] f, input int m);
		int n;
		hop_event_i <= 1'h1;
		hop_freq_i <= f;
		do @(posedge clock_i); while (hop_ready_o !== 1'h1);
		hop_event_i <= 1'h0;
		n = 0;
		for (int w = 0; w < 400 && n < 48; w++)
		begin
			@(posedge clock_i);
			if (adj_valid_o === 1'h1)
			begin
				check({adj_key_o, adj_delta_o}, {n[5:0], 9'(m * n)});
				n++;
			end
		end
		check(n, 48);
		$display("hop %0d done", f);
	endtask : t_hop

	task automatic t_load_hop;
		host.send(8'h01);
		host.send(8'h55);
		host.send(8'h01);
		check(setup_mode_o, 1'h0);
		host.send(8'h01);
		check(setup_mode_o, 1'h1);
		host.block(1'h0);
		idle_wait();
		check(crc_mismatch_o, 1'h0);
		globals(8'hE5, 8'h43, 16'hA934, 8'h08, 8'h90, 8'h14, 8'h18);
		query(3'h0, 6'h03);
		check({qd, qth}, {8'h59, 5'h0D, 5'h09});
		query(3'h6, 6'h2F);
		check(qd, 8'h5E);
		t_hop(2'h2, -2);
		t_hop(2'h1, 1);
		$display("load done");
	endtask : t_load_hop

	task automatic t_bad_crc;
		host.send(8'h01);
		host.send(8'h01);
		host.block(1'h1);
		idle_wait();
		@(posedge clock_i);
		check({crc_mismatch_o, status_n_o}, 2'h2);
		$display("bad crc done");
	endtask : t_bad_crc

	task automatic t_autofill;
		host.send(8'h02);
		idle_wait();
		query(3'h5, 6'h09);
		check(qd, 8'h48);
		query(3'h5, 6'h2F);
		check(qd, 8'hFF);
		query(3'h6, 6'h09);
		check(qd, 8'h00);
		check({crc_mismatch_o, status_n_o}, 2'h1);
		$display("auto fill done");
	endtask : t_autofill

	////////////////////////////////////////
	initial
	begin
		rst_b_i = 1'h0;
		hop_event_i = 1'h0;
		hop_freq_i = 2'h0;
		query_valid_i = 1'h0;
		query_table_i = 3'h0;
		query_key_i = 6'h00;
		key_signal_i = 16'hFFFF;
		key_error_i = 1'h0;
		touch_change_i = 1'h0;
		mains_sync_error_i = 1'h0;
		debug_i = 1'h0;
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'h1;
		idle_wait();
		t_defaults();
		t_load_hop();
		t_bad_crc();
		t_autofill();
		give_verdict();
	end

	initial
	begin
		repeat (12000) @(posedge clock_i);
		mismatches++;
		give_verdict();
	end
endmodule : touch_setups_block_loader_tb_top

`default_nettype wire
